// *** dmg_pkg.sv ***
// constants and types shared by the debug mode and command gate
// How it works
// R1: in debug state core fetch is held idle unless directed execution runs
// R2: in debug state clock and enabled peripherals keep running unless in stop
// R3: entering or being in debug state wakes the core from halt
// R4: in debug state the watchdog is refreshed every cycle when enabled
// R5: the breakpoint opcode enters debug state when breakpoints are enabled
// R6: debug pin low at reset end puts large packages straight into debug
// R7: host keeps debug pin low 5000 more cycles so no auto-baud is seen
// R8: with breakpoints disabled the breakpoint opcode acts as a no-operation
// R9: the breakpoint opcode is byte 00H, a fully programmed flash byte
// R10: host removes a breakpoint by erasing and reprogramming its flash page
// R11: a 16-bit runtime counter counts system clock cycles
// R12: counter runs from debug exit, stops on debug entry or at FFFFH
// R13: outside debug only some commands run; in debug all but protected
// R14: read protection refuses commands that would expose program memory
// R15: 00H revision, 01H reserved, 02H status, 03H counter, 04H/05H control
// R16: revision, status, control commands work outside debug; counter only in
// R17: under read protection a control write cannot clear the debug state flag
// R18: reserved and undefined command bytes are ignored with no answer
// R19: counter read answers two bytes, high byte first, count unchanged
package dmg_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] runtime_offset = 8'h08;
  localparam logic [7:0] revision_offset = 8'h0c;
  // control and status field positions
  localparam int ctrl_debug_bit = 0;
  localparam int ctrl_brk_en_bit = 1;
  localparam int stat_debug_bit = 0;
  localparam int stat_halt_bit = 1;
  localparam int stat_stop_bit = 2;
  localparam int stat_frp_bit = 3;
  // reset values and the runtime counter limit
  localparam logic ctrl_debug_reset = 1'b0;
  localparam logic ctrl_brk_en_reset = 1'b0;
  localparam logic [15:0] runtime_reset = 16'h0000;
  localparam logic [15:0] runtime_max = 16'hffff;
  // revision code is arbitrary
  localparam logic [7:0] revision_code = 8'h01;
  // opcodes and command bytes
  localparam logic [7:0] brk_opcode = 8'h00;
  localparam logic [7:0] cmd_rd_rev = 8'h00;
  localparam logic [7:0] cmd_reserved = 8'h01;
  localparam logic [7:0] cmd_rd_stat = 8'h02;
  localparam logic [7:0] cmd_rd_runtime = 8'h03;
  localparam logic [7:0] cmd_wr_ctrl = 8'h04;
  localparam logic [7:0] cmd_rd_ctrl = 8'h05;
  // host hold time of the debug pin after reset, host side only
  localparam int pin_hold_cycles = 5000;
  typedef enum logic [1:0] {
    rsp_idle = 2'b01,
    rsp_low = 2'b10
  } dmg_rsp_type;
endpackage : dmg_pkg

// *** dmg_gate.sv ***
// debug state control, runtime counter and command gate with AHB-Lite slave
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dmg_gate
  import dmg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins and straps
  input wire logic debug_pin,
  input wire logic large_package,
  input wire logic flash_read_protect_option,
  // core side
  input wire logic opcode_exec,
  input wire logic [7:0] opcode_byte,
  input wire logic directed_exec,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic wdt_enabled,
  output logic fetch_halt,
  output logic periph_run,
  output logic halt_exit,
  output logic wdt_refresh,
  output logic brk_as_nop,
  output logic debug_state_flag,
  // command bytes from the serial link framing
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_byte
);

  // true when the command may run in the present state
  function automatic logic cmd_allowed(input logic [7:0] cmd,
                                       input logic dbg);
    case (cmd)
      cmd_rd_rev, cmd_rd_stat, cmd_wr_ctrl, cmd_rd_ctrl: cmd_allowed = 1'b1;
      cmd_rd_runtime: cmd_allowed = dbg; // R16 R13
      default: cmd_allowed = 1'b0; // R18
    endcase
  endfunction : cmd_allowed

  // word index of a mapped register, 2'b00..2'b11, plus hit flag
  function automatic logic [2:0] reg_decode(input logic [31:0] addr);
    case (addr[7:0])
      ctrl_offset: reg_decode = 3'b100;
      status_offset: reg_decode = 3'b101;
      runtime_offset: reg_decode = 3'b110;
      revision_offset: reg_decode = 3'b111;
      default: reg_decode = 3'b000;
    endcase
    if (addr[31:8] != 24'h00_0000) begin
      reg_decode = 3'b000;
    end
  endfunction : reg_decode

  logic pin_meta_reg;
  logic pin_sync_reg;
  logic first_cycle_reg;
  logic brk_en_reg;
  logic debug_reg;
  logic debug_next;
  logic [15:0] runtime_reg;
  logic wr_pend_reg;
  logic [2:0] wr_sel_reg;
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic brk_hit;
  logic ahb_go;
  logic cmd_ok;
  dmg_rsp_type rsp_state_reg;
  logic [7:0] rsp_low_reg;

  assign brk_hit = opcode_exec && (opcode_byte == brk_opcode); // R9
  assign ahb_go = hsel && htrans[1] && hready;
  assign cmd_ok = cmd_valid && cmd_allowed(cmd_byte, debug_reg);

  always_comb begin
    status_byte = 8'h00;
    status_byte[stat_debug_bit] = debug_reg;
    status_byte[stat_halt_bit] = halt_mode;
    status_byte[stat_stop_bit] = stop_mode;
    status_byte[stat_frp_bit] = flash_read_protect_option;
    ctrl_byte = 8'h00;
    ctrl_byte[ctrl_debug_bit] = debug_reg;
    ctrl_byte[ctrl_brk_en_bit] = brk_en_reg;
  end

  // debug pin is asynchronous: two flops before use
  // no reset here, so the strap is already sampled when reset lifts
  always_ff @(posedge hclk) begin
    pin_meta_reg <= debug_pin;
    pin_sync_reg <= pin_meta_reg;
  end

  // marks the first edge after release, where the strap is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  // debug flag: hardware entry wins over any clear in the same cycle
  always_comb begin
    debug_next = debug_reg;
    if (wr_pend_reg && wr_sel_reg == 3'b100) begin
      debug_next = hwdata[ctrl_debug_bit];
    end else if (cmd_ok && cmd_byte == cmd_wr_ctrl) begin
      debug_next = cmd_data[ctrl_debug_bit];
    end
    if (flash_read_protect_option && debug_reg) begin
      debug_next = 1'b1; // R17
    end
    if (brk_hit && brk_en_reg) begin
      debug_next = 1'b1; // R5
    end
    if (first_cycle_reg && large_package && !pin_sync_reg) begin
      debug_next = 1'b1; // R6
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_reg <= ctrl_debug_reset;
    end else begin
      debug_reg <= debug_next;
    end
  end

  // breakpoint enable, written by bus or by the control write command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_en_reg <= ctrl_brk_en_reset;
    end else if (wr_pend_reg && wr_sel_reg == 3'b100) begin
      brk_en_reg <= hwdata[ctrl_brk_en_bit];
    end else if (cmd_ok && cmd_byte == cmd_wr_ctrl) begin
      brk_en_reg <= cmd_data[ctrl_brk_en_bit];
    end
  end

  // runtime counter restarts at debug exit and saturates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      runtime_reg <= runtime_reset;
    end else if (debug_reg && !debug_next) begin
      runtime_reg <= runtime_reset; // R12
    end else if (!debug_reg && runtime_reg != runtime_max) begin
      runtime_reg <= runtime_reg + 16'h0001; // R11 R12
    end
  end

  // core side controls, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_halt <= 1'b0;
      periph_run <= 1'b1;
      halt_exit <= 1'b0;
      wdt_refresh <= 1'b0;
      brk_as_nop <= 1'b0;
      debug_state_flag <= 1'b0;
    end else begin
      fetch_halt <= debug_next && !directed_exec; // R1
      periph_run <= !stop_mode; // R2
      halt_exit <= debug_next && halt_mode; // R3
      wdt_refresh <= debug_next && wdt_enabled; // R4
      brk_as_nop <= brk_hit && !brk_en_reg; // R8
      debug_state_flag <= debug_next;
    end
  end

  // command answers; the counter read takes two cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_state_reg <= rsp_idle;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
      rsp_low_reg <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (rsp_state_reg)
        rsp_idle: begin
          if (cmd_ok) begin // R13 R14
            rsp_valid <= (cmd_byte != cmd_wr_ctrl);
            case (cmd_byte) // R15
              cmd_rd_rev: rsp_byte <= revision_code;
              cmd_rd_stat: rsp_byte <= status_byte;
              cmd_rd_ctrl: rsp_byte <= ctrl_byte;
              cmd_rd_runtime: begin
                rsp_byte <= runtime_reg[15:8]; // R19
                rsp_low_reg <= runtime_reg[7:0];
                rsp_state_reg <= rsp_low;
              end
              default: rsp_byte <= rsp_byte;
            endcase
          end
        end
        rsp_low: begin
          rsp_valid <= 1'b1;
          rsp_byte <= rsp_low_reg; // R19
          rsp_state_reg <= rsp_idle;
        end
        default: rsp_state_reg <= rsp_idle;
      endcase
    end
  end

  // ahb-lite slave: zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= 3'b000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= ahb_go && hwrite;
      wr_sel_reg <= reg_decode(haddr);
      if (ahb_go && !hwrite) begin
        case (reg_decode(haddr))
          3'b100: hrdata <= {24'h00_0000, ctrl_byte};
          3'b101: hrdata <= {24'h00_0000, status_byte};
          3'b110: hrdata <= {16'h0000, runtime_reg};
          3'b111: hrdata <= {24'h00_0000, revision_code};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_brk_enters_debug: assert property ( // R5
    brk_hit && brk_en_reg |=> debug_reg)
    else $error("breakpoint did not enter debug");
  a_brk_nop_pulse: assert property ( // R8
    brk_hit && !brk_en_reg && !debug_reg && !first_cycle_reg
      && !(wr_pend_reg && wr_sel_reg == 3'b100 && hwdata[0])
      && !(cmd_ok && cmd_byte == cmd_wr_ctrl && cmd_data[0])
    |=> brk_as_nop && !debug_reg)
    else $error("disabled breakpoint not treated as no-operation");
  a_fetch_held: assert property ( // R1
    debug_next && !directed_exec |=> fetch_halt)
    else $error("fetch not held in debug");
  a_wdt_kept: assert property ( // R4
    $past(debug_next) && $past(wdt_enabled) |-> wdt_refresh)
    else $error("watchdog not refreshed in debug");
  a_halt_woken: assert property ( // R3
    debug_next && halt_mode |=> halt_exit)
    else $error("halt not exited in debug");
  a_runtime_counts: assert property ( // R11 R12
    !debug_reg && !debug_next && runtime_reg != runtime_max
    |=> runtime_reg == $past(runtime_reg) + 16'h0001)
    else $error("runtime counter did not count");
  a_runtime_frozen: assert property ( // R12
    debug_reg && debug_next |=> $stable(runtime_reg))
    else $error("runtime counter moved in debug");
  a_protect_keeps: assert property ( // R17
    debug_reg && flash_read_protect_option |=> debug_reg)
    else $error("debug flag cleared under read protection");
  a_counter_gated: assert property ( // R16
    cmd_valid && cmd_byte == cmd_rd_runtime && !debug_reg
      && rsp_state_reg == rsp_idle |=> !rsp_valid)
    else $error("counter read answered outside debug");
  a_counter_bytes: assert property ( // R19
    cmd_ok && cmd_byte == cmd_rd_runtime && rsp_state_reg == rsp_idle
    |=> rsp_valid && rsp_byte == $past(runtime_reg[15:8])
    ##1 rsp_valid && rsp_byte == $past(runtime_reg[7:0], 2))
    else $error("counter read bytes wrong");
  a_reserved_silent: assert property ( // R18
    cmd_valid && cmd_byte == cmd_reserved && rsp_state_reg == rsp_idle
    |=> !rsp_valid && $stable(brk_en_reg))
    else $error("reserved command answered");

  c_brk_entry: cover property (brk_hit && brk_en_reg ##1 debug_reg);
  c_strap_entry: cover property (first_cycle_reg && debug_next);
  c_counter_read: cover property (rsp_state_reg == rsp_low);
  c_debug_exit: cover property (debug_reg ##1 !debug_reg);

endmodule : dmg_gate
`default_nettype wire

// *** dmg_host.sv ***
// host debugger model: debug pin and command bytes
`timescale 1ns/100ps
`default_nettype none
module dmg_host
  import dmg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // debug link
  output logic debug_pin,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte
);
  initial begin
    debug_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_data = 8'h00;
    @(posedge hresetn);
    // long hold keeps the pin from looking like an auto-baud start
    repeat (pin_hold_cycles) @(posedge hclk);
    debug_pin <= 1'b1;
  end
  // one command, then up to two answer bytes gathered
  task automatic send(input logic [7:0] b, input logic [7:0] d,
                      output int n, output logic [15:0] v);
    n = 0;
    v = 16'h0000;
    @(posedge hclk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    cmd_data <= d;
    @(posedge hclk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
    cmd_data <= ~d;
    repeat (3) begin
      #1;
      if (rsp_valid === 1'b1) begin
        v = {v[7:0], rsp_byte};
        n++;
      end
      @(posedge hclk);
    end
  endtask : send
endmodule : dmg_host
`default_nettype wire

// *** dmg_gate_tb_top.sv ***
// self-checking bench for the debug mode and command gate
`timescale 1ns/100ps
`default_nettype none
module dmg_gate_tb_top;
  import dmg_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, debug_pin, cmd_valid, rsp_valid;
  logic large_package = 1'b1, flash_read_protect_option = 1'b0;
  logic opcode_exec = 1'b0, directed_exec = 1'b0, halt_mode = 1'b0;
  logic stop_mode = 1'b0, wdt_enabled = 1'b0;
  logic [7:0] opcode_byte = 8'h00, cmd_byte, cmd_data, rsp_byte;
  logic fetch_halt, periph_run, halt_exit, wdt_refresh, brk_as_nop, dflag;
  logic [31:0] r1, r2;
  logic [15:0] v;
  int n_mismatch = 0, n_checks = 0, n;
  always #50 hclk = ~hclk;
  dmg_gate uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .debug_pin(debug_pin),
    .large_package(large_package),
    .flash_read_protect_option(flash_read_protect_option),
    .opcode_exec(opcode_exec), .opcode_byte(opcode_byte),
    .directed_exec(directed_exec), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .wdt_enabled(wdt_enabled),
    .fetch_halt(fetch_halt), .periph_run(periph_run),
    .halt_exit(halt_exit), .wdt_refresh(wdt_refresh),
    .brk_as_nop(brk_as_nop), .debug_state_flag(dflag),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  dmg_host host (.hclk(hclk), .hresetn(hresetn), .debug_pin(debug_pin),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic step(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask : step
  task automatic exec(input logic [7:0] b, output logic no_operation);
    no_operation = 1'b0;
    @(posedge hclk);
    opcode_exec <= 1'b1;
    opcode_byte <= b;
    @(posedge hclk);
    opcode_exec <= 1'b0;
    opcode_byte <= ~b;
    repeat (3) begin
      #1;
      if (brk_as_nop === 1'b1) no_operation = 1'b1;
      @(posedge hclk);
    end
  endtask : exec
  task automatic t_entry;
    step(3);
    chk("pin entry", 1, dflag);
    chk("fetch halt", 1, fetch_halt);
    directed_exec <= 1'b1;
    stop_mode <= 1'b1;
    halt_mode <= 1'b1;
    wdt_enabled <= 1'b1;
    step(3);
    chk("directed", 0, fetch_halt);
    chk("stop", 0, periph_run);
    chk("halt exit", 1, halt_exit);
    chk("wdt refresh", 1, wdt_refresh);
    directed_exec <= 1'b0;
    stop_mode <= 1'b0;
    step(3);
    chk("run", 1, periph_run);
    chk("refetch halt", 1, fetch_halt);
    $display("test entry done");
  endtask : t_entry
  task automatic t_cmds;
    host.send(cmd_rd_rev, 8'h00, n, v);
    chk("revision", {8'h01, revision_code}, {n[7:0], v[7:0]});
    host.send(cmd_rd_stat, 8'h00, n, v);
    chk("status", 32'h0000_0103, {n[7:0], v[7:0]});
    host.send(cmd_reserved, 8'h00, n, v);
    chk("reserved", 0, n);
    host.send(8'h7f, 8'h00, n, v);
    chk("undefined", 0, n);
    $display("test cmds done");
  endtask : t_cmds
  task automatic t_runtime;
    logic no_operation;
    bus(1'b1, ctrl_offset, 32'h0000_0002, r1);
    step(3);
    chk("debug left", 0, dflag);
    host.send(cmd_rd_stat, 8'h00, n, v);
    chk("status outside", 1, n);
    host.send(cmd_rd_runtime, 8'h00, n, v);
    chk("counter refused", 0, n);
    exec(brk_opcode, no_operation);
    step(2);
    chk("brk entry", 1, dflag);
    bus(1'b0, runtime_offset, 32'h0000_0000, r1);
    step(10);
    bus(1'b0, runtime_offset, 32'h0000_0000, r2);
    chk("stopped", r1, r2);
    // fifteen cycles pass between the exit write and the breakpoint
    chk("counted", 32'h0000_000f, r1);
    host.send(cmd_rd_runtime, 8'h00, n, v);
    chk("counter cmd", {8'h02, r1[15:0]}, {n[7:0], v});
    $display("test runtime done");
  endtask : t_runtime
  task automatic t_nop;
    logic no_operation;
    bus(1'b1, ctrl_offset, 32'h0000_0002, r1);
    exec(8'h5a, no_operation);
    step(2);
    chk("other opcode", 0, dflag);
    bus(1'b1, ctrl_offset, 32'h0000_0000, r1);
    exec(brk_opcode, no_operation);
    chk("nop pulse", 1, no_operation);
    step(2);
    chk("no entry", 0, dflag);
    // page erased and reprogrammed: the original opcode runs again
    exec(8'h5a, no_operation);
    chk("restored", 0, no_operation);
    $display("test nop done");
  endtask : t_nop
  task automatic t_frp;
    flash_read_protect_option <= 1'b1;
    bus(1'b1, ctrl_offset, 32'h0000_0001, r1);
    host.send(cmd_wr_ctrl, 8'h00, n, v);
    step(3);
    chk("kept debug", 1, dflag);
    bus(1'b1, ctrl_offset, 32'h0000_0000, r1);
    bus(1'b0, status_offset, 32'h0000_0000, r1);
    chk("status frp", 32'h0000_000b, r1);
    host.send(cmd_rd_ctrl, 8'h00, n, v);
    chk("ctrl read", 32'h0000_0101, {n[7:0], v[7:0]});
    $display("test frp done");
  endtask : t_frp
  // second reset with the pin low on a small package: no strap entry
  task automatic t_small;
    flash_read_protect_option <= 1'b0;
    large_package <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    step(3);
    chk("small package", 0, dflag);
    $display("test small done");
  endtask : t_small
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_entry();
    t_cmds();
    t_runtime();
    t_nop();
    t_frp();
    t_small();
    final_report();
  end
endmodule : dmg_gate_tb_top
`default_nettype wire
